// ---- core/mmc_map_decode.sv ----
// Address window decoder for internal RAM and EEPROM
`timescale 1ns/1ps
module mmc_map_decode #(
    parameter logic [2:0] RAM_SW = 3'h2,
    parameter logic [1:0] EEP_SW = 2'h1
) (
    // Core address
    input wire logic [15:0] cpu_addr,
    // Effective RAM placement
    input wire logic [4:0] ram_base,
    input wire logic ram_high,
    // Effective EEPROM placement
    input wire logic [4:0] nv_base,
    input wire logic nv_on,
    // Decode results
    output logic ram_hit,
    output logic nv_hit
);
    import mmc_pkg::*;

    // Region exponent: 2K, 4K, 8K, 8K, 16K mappable regions
    localparam int RAM_K = (RAM_SW == 3'h0) ? 11 :
                           (RAM_SW == 3'h1) ? 12 :
                           (RAM_SW == 3'h4) ? 14 : 13;
    // Region and allocated sizes in bytes
    localparam logic [16:0] RAM_REGION = 17'(32'd1 << RAM_K);
    localparam logic [16:0] RAM_ALLOC = 17'((32'(RAM_SW) + 1) * 2048);
    localparam logic [16:0] RAM_GAP = RAM_REGION - RAM_ALLOC;
    localparam logic [15:0] RAM_MASK = 16'(32'hffff << RAM_K);
    // EEPROM window exponent: 2K, 4K, 8K
    localparam int NV_K = (EEP_SW == 2'h0) ? 11 : 10 + int'(EEP_SW);
    localparam logic [15:0] NV_MASK = 16'(32'hffff << NV_K);

    // Base addresses built from the five position bits
    wire logic [15:0] ram_floor = {ram_base, 11'h000};
    wire logic [15:0] nv_floor = {nv_base, 11'h000};
    // Region match on the used upper bits only
    wire logic ram_region = (cpu_addr & RAM_MASK) == (ram_floor & RAM_MASK);
    // Offset within the mappable region
    wire logic [16:0] ram_off = {1'b0, cpu_addr & ~RAM_MASK};
    // Lowest populated offset: zero when low aligned, gap when high aligned
    wire logic [16:0] ram_lo = ram_high ? RAM_GAP : 17'h0;
    wire logic ram_fill = (ram_off >= ram_lo) &&
                          (ram_off < 17'(ram_lo + RAM_ALLOC));

    // RAM decode: region, then populated part
    assign ram_hit = ram_region && ram_fill;
    // EEPROM decode, gone from the map while disabled or unallocated
    assign nv_hit = nv_on && (EEP_SW != 2'h0) &&
                    ((cpu_addr & NV_MASK) == (nv_floor & NV_MASK));

endmodule : mmc_map_decode

// ---- core/mmc_memory_map_config.sv ----
// Memory map configuration register bank with APB slave
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module mmc_memory_map_config #(
    parameter int ADDR_W = 8,
    parameter logic REG_SW = 1'b0,
    parameter logic [1:0] EEP_SW = 2'h1,
    parameter logic [2:0] RAM_SW = 3'h2,
    parameter logic [1:0] ROM_SW = 2'h2,
    parameter logic [1:0] PAG_SW = 2'h1,
    parameter logic NV_ONCE = 1'b0,
    parameter logic WINDOW_SPECIAL_ONLY = 1'b0,
    parameter logic [7:0] NV_RESET = 8'h00
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Operating mode from the core
    input wire logic mode_special,
    // Core address decode
    input wire logic [15:0] cpu_addr,
    output logic ram_hit,
    output logic nv_hit,
    output logic code_visible,
    output logic [5:0] window_index
);
    import mmc_pkg::*;

    // Reset values fixed by integration
    localparam logic [7:0] RAM_RESET = mmc_ram_reset(RAM_SW);
    localparam logic [5:0] WINDOW_RESET = WINDOW_SPECIAL_ONLY ?
        MMC_WINDOW_RESET_SPECIAL : MMC_WINDOW_RESET_OPEN;
    // Read-only switch views
    localparam logic [7:0] SIZE_VIEW =
        {REG_SW, 1'b0, EEP_SW, 1'b0, RAM_SW};
    localparam logic [7:0] SIZE_VIEW1 = {ROM_SW, 4'h0, PAG_SW};

    // Software registers
    logic [7:0] ram_position; // RAM base and alignment
    logic [7:0] nv_data_array_position; // EEPROM base and enable
    logic [7:0] misc_control; // Code space hide bit
    logic ram_locked; // RAM position written once
    logic nv_locked; // EEPROM base written once
    // Effective copies that steer the decoder
    logic [7:0] ram_eff;
    logic [7:0] nv_eff;
    // Read data before capture
    logic [31:0] next_rdata;

    // APB phase qualifiers
    wire logic setup = psel && !penable;
    wire logic access = psel && penable;
    wire logic wr_go = access && pwrite && pstrb[0];
    // Address selects
    wire logic [7:0] offset = 8'(paddr);
    wire logic sel_ram = offset == MMC_OFS_RAM_POS;
    wire logic sel_nv = offset == MMC_OFS_NV_POS;
    wire logic sel_size = offset == MMC_OFS_SIZE_VIEW;
    wire logic sel_size1 = offset == MMC_OFS_SIZE_VIEW1;
    wire logic sel_misc = offset == MMC_OFS_MISC;
    wire logic sel_window = offset == MMC_OFS_WINDOW;
    wire logic mapped = sel_ram || sel_nv || sel_size || sel_size1 ||
                        sel_misc || sel_window;
    // Write permissions
    wire logic ram_wr_req = wr_go && sel_ram;
    wire logic ram_wr_ok = ram_wr_req && (mode_special || !ram_locked);
    wire logic nv_wr_req = wr_go && sel_nv;
    wire logic nv_base_ok = nv_wr_req &&
        (!NV_ONCE || mode_special || !nv_locked);
    wire logic window_wr_ok = wr_go && sel_window &&
        (!WINDOW_SPECIAL_ONLY || mode_special);
    // Masked write values
    wire logic [7:0] next_ram = pwdata[7:0] & MMC_POS_MASK;
    wire logic [7:0] next_nv_base = {pwdata[MMC_BASE_MSB:MMC_BASE_LSB],
                                     3'h0};

    // APB handshake: zero wait states, error on unmapped offsets
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // Read mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (sel_ram) begin
            next_rdata = {24'h000000, ram_position};
        end else if (sel_nv) begin
            next_rdata = {24'h000000, nv_data_array_position};
        end else if (sel_size) begin
            next_rdata = {24'h000000, SIZE_VIEW};
        end else if (sel_size1) begin
            next_rdata = {24'h000000, SIZE_VIEW1};
        end else if (sel_misc) begin
            next_rdata = {24'h000000, misc_control};
        end else if (sel_window) begin
            next_rdata = {26'h0, window_index};
        end
    end

    // Read data captured in the setup phase
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= next_rdata;
        end
    end

    // RAM position with write-once lock outside special modes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ram_position <= RAM_RESET;
            ram_locked <= 1'b0;
        end else if (ram_wr_req) begin
            ram_locked <= 1'b1;
            if (ram_wr_ok) begin
                ram_position <= next_ram;
            end
        end
    end

    // EEPROM position: enable always, base by policy
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            nv_data_array_position <= NV_RESET & MMC_POS_MASK;
            nv_locked <= 1'b0;
        end else if (nv_wr_req) begin
            nv_locked <= 1'b1;
            nv_data_array_position[MMC_NV_ENABLE_BIT] <=
                pwdata[MMC_NV_ENABLE_BIT];
            if (nv_base_ok) begin
                nv_data_array_position[MMC_BASE_MSB:MMC_BASE_LSB] <=
                    next_nv_base[MMC_BASE_MSB:MMC_BASE_LSB];
            end
        end
    end

    // Miscellaneous control, hide bit only
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            misc_control <= MMC_MISC_RESET;
        end else if (wr_go && sel_misc) begin
            misc_control <= {7'h00, pwdata[MMC_CODE_HIDE_BIT]};
        end
    end

    // Program window index
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            window_index <= WINDOW_RESET;
        end else if (window_wr_ok) begin
            window_index <= pwdata[MMC_WINDOW_W-1:0];
        end
    end

    // Effective placement lags the registers by one cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ram_eff <= RAM_RESET;
            nv_eff <= NV_RESET & MMC_POS_MASK;
        end else begin
            ram_eff <= ram_position;
            nv_eff <= nv_data_array_position;
        end
    end

    // Large code spaces follow the hide bit
    assign code_visible = !(ROM_SW[1] &&
                            misc_control[MMC_CODE_HIDE_BIT]);

    // Window decoder
    mmc_map_decode #(
        .RAM_SW(RAM_SW),
        .EEP_SW(EEP_SW)
    ) u_decode (
        .cpu_addr(cpu_addr),
        .ram_base(ram_eff[MMC_BASE_MSB:MMC_BASE_LSB]),
        .ram_high(ram_eff[MMC_HIGH_ALIGN_BIT]),
        .nv_base(nv_eff[MMC_BASE_MSB:MMC_BASE_LSB]),
        .nv_on(nv_eff[MMC_NV_ENABLE_BIT]),
        .ram_hit(ram_hit),
        .nv_hit(nv_hit)
    );

    // New RAM placement lands in the map one cycle after the register
    AST_RAM_LAG: assert property (
        @(posedge clk) disable iff (!arst_n)
        (ram_wr_ok && next_ram != ram_position) |=>
            (ram_eff != ram_position) ##1 (ram_eff == $past(ram_position))
    ) else $error("RAM placement did not lag by one cycle");

    // Locked RAM position ignores writes outside special mode
    AST_RAM_ONCE: assert property (
        @(posedge clk) disable iff (!arst_n)
        (ram_wr_req && ram_locked && !mode_special) |=>
            $stable(ram_position)
    ) else $error("RAM position changed after first write");

    // First RAM write in any mode is taken
    AST_RAM_FIRST: assert property (
        @(posedge clk) disable iff (!arst_n)
        (ram_wr_req && !ram_locked) |=>
            (ram_position == $past(next_ram)) && ram_locked
    ) else $error("First RAM position write was lost");

    // RAM hits always match the upper base bits
    AST_RAM_BASE: assert property (
        @(posedge clk) disable iff (!arst_n)
        ram_hit |-> cpu_addr[15:14] == ram_eff[7:6]
    ) else $error("RAM hit outside its base");

    // EEPROM enable bit takes every write
    AST_NV_ENABLE: assert property (
        @(posedge clk) disable iff (!arst_n)
        nv_wr_req |=> nv_data_array_position[MMC_NV_ENABLE_BIT] ==
            $past(pwdata[MMC_NV_ENABLE_BIT])
    ) else $error("EEPROM enable write not taken");

    // Disabled EEPROM never decodes
    AST_NV_OFF: assert property (
        @(posedge clk) disable iff (!arst_n)
        !nv_eff[MMC_NV_ENABLE_BIT] |-> !nv_hit
    ) else $error("EEPROM decoded while disabled");

    // Size view reads the switches, writes included
    AST_SIZE_VIEW: assert property (
        @(posedge clk) disable iff (!arst_n)
        (setup && sel_size) |=> prdata == {24'h000000, SIZE_VIEW}
    ) else $error("Size view read wrong value");

    // Window index top bits read as zero
    AST_WINDOW_TOP: assert property (
        @(posedge clk) disable iff (!arst_n)
        (setup && sel_window) |=> prdata[31:6] == 26'h0
    ) else $error("Window index upper bits not zero");

    // Special-only window index refuses normal writes
    AST_WINDOW_LOCK: assert property (
        @(posedge clk) disable iff (!arst_n)
        (wr_go && sel_window && WINDOW_SPECIAL_ONLY && !mode_special) |=>
            $stable(window_index)
    ) else $error("Window index written outside special mode");

    // Hide bit removes large code spaces
    AST_CODE_HIDE: assert property (
        @(posedge clk) disable iff (!arst_n)
        (wr_go && sel_misc && pwdata[0] && ROM_SW[1]) |=> !code_visible
    ) else $error("Code space still visible after hide");

    // EEPROM placement reaches the decoder one cycle late
    AST_NV_LAG: assert property (
        @(posedge clk) disable iff (!arst_n)
        nv_wr_req |=> nv_eff == $past(nv_data_array_position)
    ) else $error("EEPROM placement moved in the write cycle");

    // Locked EEPROM base ignores writes outside special mode
    AST_NV_ONCE: assert property (
        @(posedge clk) disable iff (!arst_n)
        (nv_wr_req && NV_ONCE && nv_locked && !mode_special) |=>
            $stable(nv_data_array_position[MMC_BASE_MSB:MMC_BASE_LSB])
    ) else $error("EEPROM base changed after first write");

    // Special mode takes every RAM position write
    AST_RAM_SPECIAL: assert property (
        @(posedge clk) disable iff (!arst_n)
        (ram_wr_req && mode_special) |=> ram_position == $past(next_ram)
    ) else $error("RAM position write lost in special mode");

    // Any RAM position write closes the lock
    AST_RAM_LOCK: assert property (
        @(posedge clk) disable iff (!arst_n)
        ram_wr_req |=> ram_locked
    ) else $error("RAM position lock not set by write");

    // Window index takes every special mode write
    AST_WINDOW_SPECIAL: assert property (
        @(posedge clk) disable iff (!arst_n)
        (wr_go && sel_window && mode_special) |=>
            window_index == $past(pwdata[MMC_WINDOW_W-1:0])
    ) else $error("Window index write lost in special mode");

endmodule : mmc_memory_map_config

// ---- core/mmc_pkg.sv ----
// Shared constants for the memory map configuration block
package mmc_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] MMC_OFS_RAM_POS = 8'h00;
    localparam logic [7:0] MMC_OFS_NV_POS = 8'h04;
    localparam logic [7:0] MMC_OFS_SIZE_VIEW = 8'h08;
    localparam logic [7:0] MMC_OFS_SIZE_VIEW1 = 8'h0c;
    localparam logic [7:0] MMC_OFS_MISC = 8'h10;
    localparam logic [7:0] MMC_OFS_WINDOW = 8'h14;

    // Field positions
    localparam int MMC_BASE_MSB = 7;
    localparam int MMC_BASE_LSB = 3;
    localparam int MMC_HIGH_ALIGN_BIT = 0;
    localparam int MMC_NV_ENABLE_BIT = 0;
    localparam int MMC_CODE_HIDE_BIT = 0;
    localparam int MMC_WINDOW_W = 6;

    // Writable bit masks of the position registers
    localparam logic [7:0] MMC_POS_MASK = 8'hf9;

    // Reset values of software registers
    localparam logic [7:0] MMC_MISC_RESET = 8'h00;
    localparam logic [5:0] MMC_WINDOW_RESET_OPEN = 6'h00;
    localparam logic [5:0] MMC_WINDOW_RESET_SPECIAL = 6'h3c;

    // RAM position reset per RAM space switch (base plus high align)
    localparam logic [7:0] MMC_RAM_RESET_2K = 8'h08;
    localparam logic [7:0] MMC_RAM_RESET_4K = 8'h00;
    localparam logic [7:0] MMC_RAM_RESET_6K = 8'h01;
    localparam logic [7:0] MMC_RAM_RESET_8K = 8'h00;
    localparam logic [7:0] MMC_RAM_RESET_10K = 8'h01;

    // RAM position reset chosen by the RAM space switch
    function automatic logic [7:0] mmc_ram_reset(input logic [2:0] sw);
        case (sw)
            3'h0: mmc_ram_reset = MMC_RAM_RESET_2K;
            3'h1: mmc_ram_reset = MMC_RAM_RESET_4K;
            3'h2: mmc_ram_reset = MMC_RAM_RESET_6K;
            3'h3: mmc_ram_reset = MMC_RAM_RESET_8K;
            default: mmc_ram_reset = MMC_RAM_RESET_10K;
        endcase
    endfunction : mmc_ram_reset

endpackage : mmc_pkg

// ---- verif/mmc_core_model.sv ----
// Core-side APB master model for the memory map configuration block
`timescale 1ns/1ps
module mmc_core_model (
    // Clock
    input wire logic clk,
    // APB request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    // APB answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hf;
    end

    // One transfer, held until pready is seen at a rising edge
    task automatic xfer(input logic wr, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        // Released lines show junk so stale values cannot pass
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : mmc_core_model

// ---- verif/mmc_memory_map_config_tb_top.sv ----
// Self-checking testbench for the memory map configuration block
`timescale 1ns/1ps
module mmc_memory_map_config_tb_top;
    import mmc_pkg::*;
    // Integration switches under test
    localparam logic REG = 1'b1;
    localparam logic [1:0] EEP = 2'h1;
    localparam logic [2:0] RAM = 3'h2;
    localparam logic [1:0] ROM = 2'h3;
    localparam logic [1:0] PAG = 2'h2;
    // Expected switch views of the first build
    localparam logic [31:0] VIEW0 = {24'h0, REG, 1'b0, EEP, 1'b0, RAM};
    localparam logic [31:0] VIEW1 = {24'h0, ROM, 4'h0, PAG};
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic mode_special = 1'b0;
    logic [15:0] cpu_addr = 16'h0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic ram_hit, nv_hit, code_visible;
    logic [5:0] window_index;
    // Outputs of the second build
    logic ram_hit_b, nv_hit_b, code_visible_b;
    logic [5:0] window_index_b;
    int mismatches = 0;
    int num_checks = 0;

    // Bus clock
    always #5 clk = ~clk;

    mmc_memory_map_config #(.REG_SW(REG), .EEP_SW(EEP), .RAM_SW(RAM),
        .ROM_SW(ROM), .PAG_SW(PAG)) u_dut (.clk(clk), .arst_n(arst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mode_special(mode_special),
        .cpu_addr(cpu_addr), .ram_hit(ram_hit), .nv_hit(nv_hit),
        .code_visible(code_visible), .window_index(window_index));

    // Second build: 10K RAM, once-only EEPROM base, special-only index
    mmc_memory_map_config #(.REG_SW(1'b0), .EEP_SW(2'h3), .RAM_SW(3'h4),
        .ROM_SW(2'h1), .PAG_SW(2'h0), .NV_ONCE(1'b1),
        .WINDOW_SPECIAL_ONLY(1'b1)) u_dut_b (.clk(clk), .arst_n(arst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(), .pready(),
        .pslverr(), .mode_special(mode_special),
        .cpu_addr(cpu_addr), .ram_hit(ram_hit_b), .nv_hit(nv_hit_b),
        .code_visible(code_visible_b), .window_index(window_index_b));

    mmc_core_model u_core (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // Compare one value
    task automatic chk(input string nm, input logic [31:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        u_core.xfer(1'b1, a, d, q, e);
    endtask : wr

    // Register read with data and error compare
    task automatic rdc(input string nm, input logic [7:0] a,
            input logic [31:0] exp, input logic experr);
        logic [31:0] q;
        logic e;
        u_core.xfer(1'b0, a, 32'h0, q, e);
        chk(nm, exp, q);
        chk("pslverr", {31'h0, experr}, {31'h0, e});
    endtask : rdc

    // Present a core address and compare both decode hits
    task automatic hit(input logic [15:0] a, input logic r, input logic n);
        @(posedge clk);
        cpu_addr <= a;
        #1;
        chk("ram_hit", {31'h0, r}, {31'h0, ram_hit});
        chk("nv_hit", {31'h0, n}, {31'h0, nv_hit});
    endtask : hit

    // Verdict and end of run
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out

    // Watchdog against a hung bus
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        close_out();
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        rdc("ram_pos", 8'h00, 32'h01, 1'b0);
        rdc("nv_pos", 8'h04, 32'h00, 1'b0);
        rdc("view0", 8'h08, VIEW0, 1'b0);
        rdc("view1", 8'h0c, VIEW1, 1'b0);
        rdc("window", 8'h14, 32'h00, 1'b0);
        chk("window_b", 32'h3c, {26'h0, window_index_b});
        // 6K high aligned in the 8K region: 0x0800..0x1fff
        // Second build, 10K high aligned in 16K: 0x1800..0x3fff
        hit(16'h0800, 1'b1, 1'b0);
        chk("ram_hit_b", 32'h0, {31'h0, ram_hit_b});
        hit(16'h07ff, 1'b0, 1'b0);
        hit(16'h2000, 1'b0, 1'b0);
        chk("ram_hit_b", 32'h1, {31'h0, ram_hit_b});
        // Map moves one cycle after the write edge
        @(posedge clk);
        cpu_addr <= 16'h4000;
        wr(8'h00, 32'h40);
        #1;
        chk("ram_hit_same", 32'h0, {31'h0, ram_hit});
        @(posedge clk);
        #1;
        chk("ram_hit_next", 32'h1, {31'h0, ram_hit});
        chk("ram_hit_b", 32'h1, {31'h0, ram_hit_b});
        hit(16'h57ff, 1'b1, 1'b0);
        hit(16'h5800, 1'b0, 1'b0);
        wr(8'h00, 32'h81);
        rdc("ram_locked", 8'h00, 32'h40, 1'b0);
        @(posedge clk);
        mode_special <= 1'b1;
        wr(8'h00, 32'h81);
        rdc("ram_special", 8'h00, 32'h81, 1'b0);
        @(posedge clk);
        mode_special <= 1'b0;
        hit(16'h8800, 1'b1, 1'b0);
        hit(16'h87ff, 1'b0, 1'b0);
        wr(8'h04, 32'h81);
        rdc("nv_pos", 8'h04, 32'h81, 1'b0);
        hit(16'h8000, 1'b0, 1'b1);
        chk("nv_hit_b", 32'h1, {31'h0, nv_hit_b});
        hit(16'h7fff, 1'b0, 1'b0);
        wr(8'h04, 32'ha0);
        rdc("nv_again", 8'h04, 32'ha0, 1'b0);
        hit(16'ha000, 1'b0, 1'b0);
        wr(8'h04, 32'ha1);
        hit(16'ha000, 1'b0, 1'b1);
        // Once-only base of the second build stays at 0x8000
        hit(16'h8000, 1'b0, 1'b0);
        chk("nv_hit_b", 32'h1, {31'h0, nv_hit_b});
        wr(8'h08, 32'h00);
        rdc("view0_ro", 8'h08, VIEW0, 1'b0);
        rdc("unmapped", 8'h20, 32'h0, 1'b1);
        chk("code_vis", 32'h1, {31'h0, code_visible});
        wr(8'h10, 32'h01);
        #1;
        chk("code_hid", 32'h0, {31'h0, code_visible});
        chk("code_vis_b", 32'h1, {31'h0, code_visible_b});
        wr(8'h14, 32'hff);
        rdc("window", 8'h14, 32'h3f, 1'b0);
        chk("window_out", 32'h3f, {26'h0, window_index});
        chk("window_b", 32'h3c, {26'h0, window_index_b});
        // Special mode opens the index of the second build
        @(posedge clk);
        mode_special <= 1'b1;
        wr(8'h14, 32'h05);
        #1;
        chk("window_b_sp", 32'h05, {26'h0, window_index_b});
        @(posedge clk);
        mode_special <= 1'b0;
        // Second reset clears the RAM position write-once lock
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rdc("ram_rst", 8'h00, 32'h01, 1'b0);
        rdc("window_rst", 8'h14, 32'h00, 1'b0);
        chk("window_b_rst", 32'h3c, {26'h0, window_index_b});
        wr(8'h00, 32'h40);
        rdc("ram_first", 8'h00, 32'h40, 1'b0);
        close_out();
    end
endmodule : mmc_memory_map_config_tb_top
